// *** hdl/ccst_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccst_timer
  import ccst_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_ref_clk,
  input  wire logic               i_prepare,
  input  wire logic               i_power_rst,
  input  wire logic               i_reread,
  input  wire logic               i_short_read,
  output logic                    o_gated_4800,
  output logic                    o_cathode_pulse,
  output logic                    o_hsync,
  output logic                    o_video_clamp,
  output logic                    o_shutter_open,
  output logic                    o_shutter_close,
  output logic                    o_target_lamp,
  output logic                    o_white_clamp,
  output logic                    o_video_switch,
  output logic                    o_control_grid_regulator,
  output logic                    o_mesh_relay,
  output logic                    o_target_relay,
  output logic                    o_chopper_sync,
  output logic                    o_mod_carrier,
  output logic                    o_interval_period_signal,
  output logic                    o_hold,
  output logic [SWEEP_W-1:0]      o_sweep
);

  logic               ref_prev_reg;
  logic               tick;
  logic [PRE_W-1:0]   pre_reg;
  logic               pre_wrap;
  logic [6:0]         mid_reg;
  logic               line_tick;
  logic [11:0]        lpos;
  logic               hsync;
  ccst_state_t        state_reg;
  logic               pend_reg;
  logic               start;
  logic [IVL_W-1:0]   ivl_reg;
  logic [SWEEP_W-1:0] sweep_reg;
  logic [SWEEP_W-1:0] read_end;
  logic               read_done;
  logic               in_ivl;
  logic               in_read;
  logic               prep;
  logic               expo;
  logic               shut1;
  logic               shut2;

  // Position within one horizontal line in reference ticks
  function automatic logic [11:0] line_pos(
    input logic [6:0]       mid,
    input logic [PRE_W-1:0] pre
  );
    line_pos = {mid, pre};
  endfunction

  // True while a count sits inside a window starting at base
  function automatic logic in_win(
    input logic [IVL_W-1:0] cnt,
    input logic [IVL_W-1:0] base,
    input logic [IVL_W-1:0] len
  );
    in_win = (cnt >= base) && (cnt < IVL_W'(base + len));
  endfunction

  // Reference edge becomes a one-cycle enable
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // Starts high so a reference already high at release is no edge
      ref_prev_reg <= 1'b1;
    end else begin
      ref_prev_reg <= i_ref_clk;
    end
  end

  assign tick = i_ref_clk & ~ref_prev_reg;

  // First stages: 4800, 2400, 1200, 600, 300 Hz
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pre_reg <= '0;
    end else if (tick) begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  assign pre_wrap = tick & (&pre_reg);

  // Line divider, 300 Hz down to the 4 Hz line rate
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mid_reg <= '0;
    end else if (pre_wrap) begin
      if (mid_reg == LINE_DIV - 7'h01) begin
        mid_reg <= '0;
      end else begin
        mid_reg <= mid_reg + 7'h01;
      end
    end
  end

  assign line_tick = pre_wrap && (mid_reg == LINE_DIV - 7'h01);
  assign lpos      = line_pos(mid_reg, pre_reg);
  assign hsync     = lpos < HSYNC_TICKS;

  // Prepare waits for the next reference tick; ignored outside hold
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pend_reg <= 1'b0;
    end else if (i_power_rst || state_reg != ST_HOLD) begin
      pend_reg <= 1'b0;
    end else if (i_prepare) begin
      pend_reg <= 1'b1;
    end else if (start) begin
      pend_reg <= 1'b0;
    end
  end

  assign start = (state_reg == ST_HOLD) && pend_reg && tick;

  // Short read is a test aid; normal flights leave it low
  assign read_end  = i_short_read ? SHORT_LINES : READ_LINES;
  assign read_done = line_tick &&
                     (SWEEP_W'(sweep_reg + 1'b1) >= read_end);

  // Cycle sequencer; power reset overrides everything
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= ST_HOLD;
    end else if (i_power_rst) begin
      state_reg <= ST_WARM;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (start) begin
            state_reg <= ST_IVL;
          end else if (i_reread) begin
            state_reg <= ST_READ;
          end
        end
        ST_IVL: begin
          if (tick && ivl_reg == IVL_TICKS - 1'b1) begin
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (read_done) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg <= ST_READ;
        end
      endcase
    end
  end

  // Interval counter in reference ticks, cleared outside it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ivl_reg <= '0;
    end else if (state_reg != ST_IVL) begin
      ivl_reg <= '0;
    end else if (tick) begin
      ivl_reg <= ivl_reg + 1'b1;
    end
  end

  // Final 10-stage divider, steps once per line during readout
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sweep_reg <= '0;
    end else if (i_power_rst) begin
      sweep_reg <= WARM_PRESET;
    end else if (state_reg == ST_IVL) begin
      sweep_reg <= '0;
    end else if (state_reg == ST_HOLD && i_reread && !start) begin
      sweep_reg <= '0;
    end else if (state_reg == ST_READ && line_tick) begin
      sweep_reg <= sweep_reg + 1'b1;
    end
  end

  // Phase decodes of the state and the interval counter
  assign in_ivl  = state_reg == ST_IVL;
  assign in_read = state_reg == ST_READ;
  assign prep    = in_ivl && (ivl_reg < PREP_TICKS);
  assign expo    = in_ivl && (ivl_reg >= PREP_TICKS) &&
                   (ivl_reg < EXP_END);
  assign shut1   = in_ivl &&
                   in_win(ivl_reg, SHUT1_TICKS, SHWID_TICKS);
  assign shut2   = in_ivl &&
                   in_win(ivl_reg, SHUT2_TICKS, SHWID_TICKS);

  // Registered output decodes; one clock behind the counters
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_gated_4800             <= 1'b0;
      o_cathode_pulse          <= 1'b0;
      o_hsync                  <= 1'b0;
      o_video_clamp            <= 1'b0;
      o_shutter_open           <= 1'b0;
      o_shutter_close          <= 1'b0;
      o_target_lamp            <= 1'b0;
      o_white_clamp            <= 1'b0;
      o_video_switch           <= 1'b0;
      o_control_grid_regulator <= 1'b0;
      o_mesh_relay             <= 1'b0;
      o_target_relay           <= 1'b0;
      o_chopper_sync           <= 1'b0;
      o_mod_carrier            <= 1'b0;
      o_interval_period_signal <= 1'b0;
      o_hold                   <= 1'b1;
      o_sweep                  <= '0;
    end else begin
      // Sampling gated off during blanking
      o_gated_4800    <= in_read & pre_reg[0] & ~hsync;
      o_cathode_pulse <= in_read & (&pre_reg[1:0]);
      o_hsync         <= hsync;
      o_video_clamp   <= hsync & in_read;
      o_shutter_open  <= shut1;
      o_shutter_close <= shut2;
      o_target_lamp   <= prep;
      // Phasing rides on the sync slot, tone fills the rest
      o_white_clamp   <= in_ivl & (hsync | pre_reg[4]);
      o_video_switch  <= in_ivl | (in_read & hsync);
      o_control_grid_regulator <= prep | expo;
      o_mesh_relay    <= in_ivl;
      o_target_relay  <= prep;
      // Chopper edges land on falling 4800 Hz edges, away from samples
      o_chopper_sync  <= pre_reg[1];
      o_mod_carrier   <= pre_reg[1];
      o_interval_period_signal <= in_ivl;
      o_hold          <= state_reg == ST_HOLD;
      o_sweep         <= sweep_reg;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  prep_ignore_a: assert property (
    (state_reg != ST_HOLD && !pend_reg) |=> !pend_reg)
    else $error("prepare accepted outside hold");

  interval_start_a: assert property (
    (start && !i_power_rst) |=> state_reg == ST_IVL ##1 ivl_reg == 0)
    else $error("interval did not start");

  interval_len_a: assert property (
    (in_ivl && tick && ivl_reg == IVL_TICKS - 1'b1 && !i_power_rst)
    |=> in_read && sweep_reg == 0)
    else $error("interval length wrong");

  read_end_a: assert property (
    (in_read && read_done && !i_power_rst) |=> state_reg == ST_HOLD)
    else $error("readout did not end in hold");

  hold_stay_a: assert property (
    (state_reg == ST_HOLD && !start && !i_reread && !i_power_rst)
    |=> state_reg == ST_HOLD)
    else $error("hold left without cause");

  warm_preset_a: assert property (
    i_power_rst |=> state_reg == ST_WARM && sweep_reg == WARM_PRESET)
    else $error("power reset preset wrong");

  warm_release_a: assert property (
    (state_reg == ST_WARM && !i_power_rst)
    |=> in_read && sweep_reg == WARM_PRESET)
    else $error("warm-up readout not started");

  sweep_step_a: assert property (
    (in_read && !line_tick && !i_power_rst) |=> $stable(sweep_reg))
    else $error("sweep moved between lines");

  shutter_a: assert property (
    (in_ivl && ivl_reg == SHUT1_TICKS) |=> o_shutter_open && !o_shutter_close)
    else $error("first shutter pulse missing");

  gated_a: assert property (
    o_gated_4800 |-> $past(state_reg) == ST_READ)
    else $error("sampling gate outside readout");

  tone_a: assert property (
    o_white_clamp |-> $past(in_ivl) && o_interval_period_signal)
    else $error("tone outside interval");

  // Relations of the registered decodes and counters; the clamp, gate, relay, lamp and switch checks share one clock edge
  clamp_gate_a: assert property (
    o_video_clamp |-> o_hsync)
    else $error("clamp outside sync slot");

  gate_blank_a: assert property (
    o_gated_4800 |-> !o_hsync)
    else $error("sampling gate during blanking");

  cathode_read_a: assert property (
    o_cathode_pulse |-> $past(in_read))
    else $error("cathode pulse outside readout");

  relay_phase_a: assert property (
    o_target_relay |-> o_control_grid_regulator && o_mesh_relay)
    else $error("relay outside grid phase");

  lamp_phase_a: assert property (
    o_target_lamp |-> o_interval_period_signal && o_target_relay)
    else $error("lamp outside prepare phase");

  switch_ivl_a: assert property (
    o_interval_period_signal |-> o_video_switch)
    else $error("video switch off in interval");

  shutter_close_a: assert property (
    (in_ivl && ivl_reg == SHUT2_TICKS)
    |=> o_shutter_close && !o_shutter_open)
    else $error("second shutter pulse missing");

  prep_drop_a: assert property (
    i_power_rst |=> !pend_reg)
    else $error("prepare kept through power reset");

  sweep_up_a: assert property (
    (in_read && line_tick && !i_power_rst)
    |=> sweep_reg == SWEEP_W'($past(sweep_reg) + 1'b1))
    else $error("sweep missed a line step");

  // Main paths of the cycle
  ivl_to_read_c: cover property (in_ivl ##1 in_read);
  read_to_hold_c: cover property (in_read ##1 state_reg == ST_HOLD);
  shutter_c: cover property ($rose(o_shutter_close));
  warm_c: cover property (state_reg == ST_WARM ##1 in_read);
  reread_c: cover property (state_reg == ST_HOLD && i_reread ##1 in_read);

endmodule // ccst_timer
`default_nettype wire

// *** hdl/ccst_pkg.sv ***
// How it works
// - Every count and output derives from the 9600 Hz reference clock.
// - Each output is a decode of counter stages along the chain.
// - A prepare pulse runs 8 s of prepare/expose/delay, then 150 s read.
// - After readout hold indefinitely until the next prepare pulse.
// - Power reset presets the final counter mid-readout and holds it.
// - On release a 48 s partial readout runs, then hold.
// - Reread and 22 s short read inputs exist for test only.
// - Final 10-stage binary divider feeds the vertical sweep converter.
// - Gated 4800 Hz output triggers the video sampling one-shot.
// - A 2400 Hz square wave syncs the supply chopper between samples.
// - A separate 2400 Hz square wave is the modulator carrier.
// - During the interval emit a 300 Hz tone and phasing pulses.
// - Video switch timing selects tone, phasing and white clamp.
// - Interval period signal is high for the whole 8 s interval.
// - Two shutter pulses open and close the shutter within the exposure.
// - A 5 percent horizontal sync and matching clamp timing.
// - Grid regulator, mesh, target relays and lamp switch in interval.
// - A cathode pulse supplies the tube sampling input.
// - Interval splits into 5 s prepare, 1 s expose, 2 s delay.
// - First shutter at 5.500 s, second 25 ms after the first.
package ccst_pkg;

  localparam int REF_HZ    = 9600;
  localparam int LINE_HZ   = 4;
  localparam int PRE_W     = 5;
  localparam int SWEEP_W   = 10;
  localparam int IVL_W     = 17;

  // Times in their own units
  localparam int IVL_MS    = 8000;
  localparam int PREP_MS   = 5000;
  localparam int EXP_MS    = 1000;
  localparam int SHUT1_MS  = 5500;
  localparam int SHGAP_MS  = 25;
  localparam int SHWID_MS  = 10;
  localparam int READ_S    = 150;
  localparam int WARM_S    = 48;
  localparam int SHORT_S   = 22;
  localparam int HSYNC_PCT = 5;

  // Counts of reference ticks and of lines
  localparam logic [IVL_W-1:0] IVL_TICKS =
    IVL_W'(IVL_MS * REF_HZ / 1000);
  localparam logic [IVL_W-1:0] PREP_TICKS =
    IVL_W'(PREP_MS * REF_HZ / 1000);
  localparam logic [IVL_W-1:0] EXP_END =
    IVL_W'((PREP_MS + EXP_MS) * REF_HZ / 1000);
  localparam logic [IVL_W-1:0] SHUT1_TICKS =
    IVL_W'(SHUT1_MS * REF_HZ / 1000);
  localparam logic [IVL_W-1:0] SHUT2_TICKS =
    IVL_W'((SHUT1_MS + SHGAP_MS) * REF_HZ / 1000);
  localparam logic [IVL_W-1:0] SHWID_TICKS =
    IVL_W'(SHWID_MS * REF_HZ / 1000);
  localparam logic [6:0] LINE_DIV =
    7'(REF_HZ / (1 << PRE_W) / LINE_HZ);
  localparam logic [11:0] HSYNC_TICKS =
    12'(REF_HZ / LINE_HZ * HSYNC_PCT / 100);
  localparam logic [SWEEP_W-1:0] READ_LINES =
    SWEEP_W'(READ_S * LINE_HZ);
  localparam logic [SWEEP_W-1:0] SHORT_LINES =
    SWEEP_W'(SHORT_S * LINE_HZ);
  localparam logic [SWEEP_W-1:0] WARM_PRESET =
    SWEEP_W'((READ_S - WARM_S) * LINE_HZ);

  // Gray codes along hold, interval, read
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_IVL  = 2'b01,
    ST_READ = 2'b11,
    ST_WARM = 2'b10
  } ccst_state_t;

endpackage

// *** testbench/ccst_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccst_prog_model (
  input  wire logic i_clk,
  input  wire logic i_fire,
  output logic      o_ref_clk,
  output logic      o_prepare
);
  logic       ref_reg   = 1'b0;
  logic [1:0] pulse_cnt = 2'h0;

  // Fastest reference the timer accepts, so long counts fit in a short run
  always @(negedge i_clk) begin
    ref_reg <= ~ref_reg;
  end

  assign o_ref_clk = ref_reg;

  // Two-cycle prepare pulse, only when asked; the next cycle needs a new one.
  // Taken on the rising edge, where the bench's request stands still.
  always @(posedge i_clk) begin
    if (i_fire) begin
      pulse_cnt <= 2'h2;
    end else if (pulse_cnt != 2'h0) begin
      pulse_cnt <= pulse_cnt - 2'h1;
    end
  end

  always_comb o_prepare = (pulse_cnt != 2'h0);
endmodule // ccst_prog_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccst_pkg::*;
  localparam int TPC = 2; // i_clk cycles per reference tick
  localparam logic [SWEEP_W-1:0] WARM_AT =
    SWEEP_W'((READ_S - WARM_S) * LINE_HZ);
  logic i_clk, i_rstn, i_power_rst, i_reread, i_short_read, fire;
  logic ref_clk, prepare, gated, cath, hsync, vclamp, sh_open, sh_close;
  logic lamp, wclamp, vsw, grid, mesh, target, chop, carr, ivl, hold;
  logic [SWEEP_W-1:0] sweep;
  int   fails, n_tests, k, hi, per, cnt_g, cnt_c, cnt_w, bad;

  ccst_prog_model i_prog (.i_clk(i_clk), .i_fire(fire),
    .o_ref_clk(ref_clk), .o_prepare(prepare));

  ccst_timer i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ref_clk(ref_clk),
    .i_prepare(prepare), .i_power_rst(i_power_rst), .i_reread(i_reread),
    .i_short_read(i_short_read), .o_gated_4800(gated),
    .o_cathode_pulse(cath), .o_hsync(hsync), .o_video_clamp(vclamp),
    .o_shutter_open(sh_open), .o_shutter_close(sh_close),
    .o_target_lamp(lamp), .o_white_clamp(wclamp), .o_video_switch(vsw),
    .o_control_grid_regulator(grid), .o_mesh_relay(mesh),
    .o_target_relay(target), .o_chopper_sync(chop), .o_mod_carrier(carr),
    .o_interval_period_signal(ivl), .o_hold(hold), .o_sweep(sweep));

  // 20 MHz system clock
  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("Counts: %0d mismatches in %0d comparisons", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    fails++;
    $display("Error at %0t: timed out waiting for %s", $time, what);
    end_of_test();
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string s);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b expected %b", $time, s, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [SWEEP_W-1:0] got,
                         input logic [SWEEP_W-1:0] exp, input string s);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %0d expected %0d", $time, s, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string s);
    n_tests++;
    if (got != exp) begin
      fails++;
      $display("Error at %0t: %s got %0d expected %0d", $time, s, got, exp);
    end
  endtask

  // Cycles of i_clk in one period of a signal of the given rate
  function automatic int cyc(input int hz);
    return TPC * REF_HZ / hz;
  endfunction

  function automatic logic pick(input int s);
    return (s == 0) ? chop : hsync;
  endfunction

  // High time and period of chopper (0) or sync (1), bounded
  task automatic meas(input int s, output int h, output int p);
    int lo;
    for (k = 0; k < 9999 && pick(s) !== 1'b0; k++) @(negedge i_clk);
    if (k == 9999) hang("low level");
    for (k = 0; k < 9999 && pick(s) !== 1'b1; k++) @(negedge i_clk);
    if (k == 9999) hang("high level");
    h = 0;
    lo = 0;
    while (pick(s) === 1'b1 && h < 9999) begin
      h++;
      @(negedge i_clk);
    end
    while (pick(s) === 1'b0 && lo < 9999) begin
      lo++;
      @(negedge i_clk);
    end
    p = h + lo;
    if (h == 9999 || lo == 9999) hang("level change");
  endtask

  // Waits for the next line step, watching readout outputs meanwhile
  task automatic wait_sweep(input logic [SWEEP_W-1:0] from);
    cnt_g = 0;
    cnt_c = 0;
    bad = 0;
    for (k = 0; k < 6000 && sweep === from; k++) begin
      @(negedge i_clk);
      cnt_g += int'(gated === 1'b1);
      cnt_c += int'(cath === 1'b1);
      bad += int'(vclamp !== hsync);
    end
    if (k == 6000) hang("line step");
  endtask

  initial begin
    #5ms;
    hang("end of run");
  end

  initial begin
    void'($urandom(32'h1605E8C0));
    i_rstn = 1'b0;
    i_power_rst = 1'b0;
    i_reread = 1'b0;
    i_short_read = 1'b0;
    fire = 1'b0;
    repeat (8) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    chk_bit(hold, 1'b1, "hold after reset");
    chk_bit(ivl, 1'b0, "interval after reset");
    meas(0, hi, per);
    chk_num(per, cyc(2400), "chopper period");
    chk_num(hi, cyc(2400) / 2, "chopper high");
    bad = 0;
    repeat (40) begin
      @(negedge i_clk);
      bad += int'(carr !== chop);
    end
    chk_num(bad, 0, "carrier square");
    meas(1, hi, per);
    chk_num(per, cyc(LINE_HZ), "line period");
    chk_num(hi, cyc(LINE_HZ) * HSYNC_PCT / 100, "sync width");
    // Picture cycle from hold at a random moment
    repeat ($urandom_range(1, 40)) @(negedge i_clk);
    fire = 1'b1;
    @(negedge i_clk);
    fire = 1'b0;
    for (k = 0; k < 50 && ivl !== 1'b1; k++) @(negedge i_clk);
    if (k == 50) hang("interval start");
    chk_bit(hold, 1'b0, "hold in interval");
    chk_vec(sweep, '0, "sweep at start");
    chk_bit(mesh, 1'b1, "mesh relay");
    chk_bit(target, 1'b1, "target relay");
    chk_bit(lamp, 1'b1, "target lamp");
    chk_bit(grid, 1'b1, "grid regulator");
    chk_bit(vsw, 1'b1, "video switch");
    // Stray reread and prepare in mid-interval are ignored
    repeat ($urandom_range(5, 60)) @(negedge i_clk);
    i_reread = 1'b1;
    fire = 1'b1;
    @(negedge i_clk);
    i_reread = 1'b0;
    fire = 1'b0;
    cnt_w = 0;
    bad = 0;
    repeat (2000) begin
      @(negedge i_clk);
      cnt_w += int'(wclamp === 1'b1);
      bad += int'(sh_open !== 1'b0 || sh_close !== 1'b0 || cath !== 1'b0);
    end
    chk_bit(cnt_w > 0 && cnt_w < 2000, 1'b1, "start tone");
    chk_num(bad, 0, "no early shutter");
    chk_bit(ivl, 1'b1, "interval holds");
    chk_vec(sweep, '0, "reread ignored");
    // Power reset in mid-interval, with a prepare that must be dropped
    i_power_rst = 1'b1;
    fire = 1'b1;
    @(negedge i_clk);
    fire = 1'b0;
    repeat (20) @(negedge i_clk);
    chk_vec(sweep, WARM_AT, "warm preset");
    chk_bit(ivl, 1'b0, "interval cut");
    chk_bit(hold, 1'b0, "not hold in warm");
    i_power_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    chk_vec(sweep, WARM_AT, "warm read start");
    wait_sweep(sweep);
    chk_vec(sweep, WARM_AT + 10'h001, "line step");
    chk_num(bad, 0, "clamp follows sync");
    chk_bit(cnt_g > 0, 1'b1, "gated 4800 runs");
    chk_bit(cnt_c > 0, 1'b1, "cathode pulses");
    // Short read with sweep past its end stops at the next line
    i_short_read = 1'b1;
    for (k = 0; k < 6000 && hold !== 1'b1; k++) @(negedge i_clk);
    if (k == 6000) hang("short read end");
    // Sweep already lies past the short end, so one more line step ends it
    chk_vec(sweep, WARM_AT + 10'h002, "short read end");
    i_short_read = 1'b0;
    repeat (100) @(negedge i_clk);
    chk_bit(hold, 1'b1, "stays in hold");
    // Reread from hold restarts the sweep at zero
    repeat ($urandom_range(1, 30)) @(negedge i_clk);
    i_reread = 1'b1;
    @(negedge i_clk);
    i_reread = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_bit(hold, 1'b0, "reread leaves hold");
    chk_vec(sweep, '0, "reread sweep");
    wait_sweep(sweep);
    chk_vec(sweep, 10'h001, "reread step");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
